/* File: shared/lpse_defs.svh */
/*
 * Constants of the LED pulse stream encoder: register offsets, field
 * positions, reset values, instruction encoding and program layout.
 * Assumes inclusion by bare name from design files that need them.
 */
`ifndef LPSE_DEFS_SVH
`define LPSE_DEFS_SVH

// Register offsets (byte addresses)
`define LPSE_ADDR_CTRL       8'h00
`define LPSE_ADDR_CLKDIV     8'h04
`define LPSE_ADDR_TIMING     8'h08
`define LPSE_ADDR_TXDATA     8'h0c
`define LPSE_ADDR_STATUS     8'h10

// Reset values
`define LPSE_CTRL_RESET      32'h0000_0184
`define LPSE_TIMING_RESET    32'h0004_0303
`define LPSE_CLKDIV_RESET    16'h0002

// Control field positions
`define LPSE_CTRL_ENABLE     0
`define LPSE_CTRL_SHIFT_RIGHT 1
`define LPSE_CTRL_AUTOPULL   2
`define LPSE_CTRL_THRESH_LO  4
`define LPSE_CTRL_THRESH_HI  8

// Timing field positions (cycles, 1..16 usable)
`define LPSE_TIM_LEAD_LO     0
`define LPSE_TIM_LEAD_HI     4
`define LPSE_TIM_VALUE_LO    8
`define LPSE_TIM_VALUE_HI    12
`define LPSE_TIM_GAP_LO      16
`define LPSE_TIM_GAP_HI      20

// Status field positions
`define LPSE_ST_QUEUE_FULL   0
`define LPSE_ST_STALLED      1
`define LPSE_ST_LINE         2
`define LPSE_ST_PC_LO        3
`define LPSE_ST_PC_HI        4
`define LPSE_ST_CNT_LO       5
`define LPSE_ST_CNT_HI       10

// Instruction encoding
`define LPSE_OP_JMP          3'h0
`define LPSE_OP_OUT          3'h3
`define LPSE_OP_MOV          3'h5
`define LPSE_COND_ALWAYS     3'h0
`define LPSE_COND_NOT_X      3'h1
`define LPSE_DEST_X          3'h1
`define LPSE_NOP_OPERAND     8'h42
`define LPSE_OUT_ONE_BIT     5'h01

// Program layout
`define LPSE_PC_BITLOOP      5'h00
`define LPSE_PC_BRANCH       5'h01
`define LPSE_PC_DO_ONE       5'h02
`define LPSE_PC_DO_ZERO      5'h03
`define LPSE_PC_WRAP_TARGET  5'h00
`define LPSE_PC_WRAP         5'h03

// Shift register geometry
`define LPSE_OSR_FULL_COUNT  6'h20

`endif

/* File: shared/lpse_pkg.sv */
/*
 * Types of the LED pulse stream encoder: configuration and instruction
 * layouts. Assumes lpse_defs.svh supplies the numeric constants.
 */
package lpse_pkg;

	typedef struct packed {
		logic [4:0] thresh;
		logic       autopull;
		logic       shift_right;
		logic       enable;
	} lpse_cfg_t;

	typedef struct packed {
		logic [4:0] gap;
		logic [4:0] value;
		logic [4:0] lead;
	} lpse_timing_t;

	// 16-bit word: op, one side-set bit, four delay bits, operand
	typedef struct packed {
		logic [2:0] op;
		logic       side;
		logic [3:0] delay;
		logic [7:0] operand;
	} lpse_instr_t;

endpackage : lpse_pkg

/* File: hdl/lpse_exec_tick.sv */
/*
 * Execution-rate divider: one-cycle enable pulse every divisor clocks.
 * Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps

module lpse_exec_tick #(
	parameter int WIDTH = 16
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             run,
	input  wire logic [WIDTH-1:0] divisor,
	output logic                  tick
);

	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic             next_tick;
	logic [WIDTH-1:0] limit;

	always_comb begin
		limit      = (divisor == '0) ? '0 : divisor - 1'b1;
		next_count = count;
		next_tick  = 1'b0;
		if (!run) begin
			next_count = '0;
		end else if (count >= limit) begin
			next_count = '0;
			next_tick  = 1'b1;
		end else begin
			next_count = count + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			count <= '0;
			tick  <= 1'b0;
		end else begin
			count <= next_count;
			tick  <= next_tick;
		end
	end

endmodule : lpse_exec_tick

/* File: hdl/lpse_top.sv */
/*
 * LED pulse stream encoder: register port, one-word transmit queue,
 * output shift register and a fixed four-instruction bit program that
 * turns each data bit into a width-coded high pulse on one line.
 * Assumes a 20 MHz clock, synchronous reset, and a host that never
 * pushes while the queue reports full.
 */
// Design decisions made here: strobed register access and the register offsets.
// Summary of operation
// - Every data bit leaves as one positive pulse; width gives its value.
// - A long low period latches the colour data in the LEDs.
// - Default timing: lead 3, value 3, gap 4 cycles.
// - Step one drives low, shifts one bit to scratch, lasts gap cycles.
// - Side-set level applies even while the shift step stalls.
// - Step two drives high for lead cycles and branches on a zero bit.
// - One bit stays high value cycles more, then loops back.
// - Zero bit drives low value cycles doing nothing else.
// - Instructions are 16 bits with a delay applied after completion.
// - One side-set bit leaves a four-bit delay of 0 to 15.
// - Every instruction drives its side-set value once.
// - Shift register loads whole 32-bit words from the queue.
// - Shift count from the instruction, direction from configuration.
// - Enabled machine with autopull stalls on empty queue and resumes on data.
// - All counts are execution cycles, slowed by the divider.
// - Wrap returns to the target with no extra cycle unless jumping.
// - Autopull refills in the background after the threshold count.
// - Shifting fills with zeroes once all loaded bits are gone.
`timescale 1ns/1ps

`include "lpse_defs.svh"

module lpse_top #(
	parameter logic [15:0] CLKDIV_RESET = `LPSE_CLKDIV_RESET
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [31:0]      rdata,
	output logic             led_line
);

	lpse_pkg::lpse_cfg_t    cfg;
	lpse_pkg::lpse_timing_t timing;
	logic [15:0]            clkdiv;
	logic [31:0]            q_word;
	logic                   q_full;
	logic [31:0]            outgoing_shift_reg;
	logic [5:0]             shift_cnt;
	logic [4:0]             pc;
	logic [3:0]             delay_cnt;
	logic                   scratch_x;
	logic                   stalled;

	lpse_pkg::lpse_cfg_t    next_cfg;
	lpse_pkg::lpse_timing_t next_timing;
	logic [15:0]            next_clkdiv;
	logic [31:0]            next_q_word;
	logic                   next_q_full;
	logic [31:0]            next_outgoing_shift_reg;
	logic [5:0]             next_shift_cnt;
	logic [4:0]             next_pc;
	logic [3:0]             next_delay_cnt;
	logic                   next_scratch_x;
	logic                   next_stalled;
	logic                   next_led_line;
	logic [31:0]            next_rdata;

	logic                   exec_tick;
	lpse_pkg::lpse_instr_t  instr;
	logic [5:0]             thresh_bits;
	logic [5:0]             out_bits;
	logic [4:0]             seq_pc;
	logic                   need_pull;
	logic                   pop;
	logic [31:0]            src_word;
	logic [5:0]             src_cnt;
	logic [31:0]            out_value;
	logic [6:0]             cnt_sum;

	// Reset fields are picked one by one; the control map has a hole at bit 3
	localparam logic [31:0] CTRL_RST   = `LPSE_CTRL_RESET;
	localparam logic [31:0] TIMING_RST = `LPSE_TIMING_RESET;

	// Execution-rate enable
	lpse_exec_tick #(
		.WIDTH   (16)
	) u_tick (
		.clk     (clk),
		.reset   (reset),
		.run     (cfg.enable),
		.divisor (clkdiv),
		.tick    (exec_tick)
	);

	// Build a 16-bit word; delay field is cycles minus one in four bits
	function automatic lpse_pkg::lpse_instr_t make_instr(
		input logic [2:0] op,
		input logic       side,
		input logic [4:0] cycles,
		input logic [7:0] operand
	);
		lpse_pkg::lpse_instr_t w;
		logic [4:0]            d;
		d         = (cycles == 5'h00) ? 5'h00 : cycles - 5'h01;
		w.op      = op;
		w.side    = side;
		w.delay   = d[3:0];
		w.operand = operand;
		return w;
	endfunction : make_instr

	// Program memory, rebuilt from the timing register
	always_comb begin
		case (pc)
			`LPSE_PC_BITLOOP: instr = make_instr(`LPSE_OP_OUT, 1'b0, timing.gap,
				{`LPSE_DEST_X, `LPSE_OUT_ONE_BIT});
			`LPSE_PC_BRANCH:  instr = make_instr(`LPSE_OP_JMP, 1'b1, timing.lead,
				{`LPSE_COND_NOT_X, `LPSE_PC_DO_ZERO});
			`LPSE_PC_DO_ONE:  instr = make_instr(`LPSE_OP_JMP, 1'b1, timing.value,
				{`LPSE_COND_ALWAYS, `LPSE_PC_BITLOOP});
			`LPSE_PC_DO_ZERO: instr = make_instr(`LPSE_OP_MOV, 1'b0, timing.value,
				`LPSE_NOP_OPERAND);
			default:          instr = make_instr(`LPSE_OP_MOV, 1'b0, 5'h01, `LPSE_NOP_OPERAND);
		endcase
	end

	always_comb begin
		thresh_bits = (cfg.thresh == 5'h00) ? `LPSE_OSR_FULL_COUNT : {1'b0, cfg.thresh};
		out_bits    = (instr.operand[4:0] == 5'h00) ? `LPSE_OSR_FULL_COUNT : {1'b0, instr.operand[4:0]};
		// Wrap costs no cycle
		seq_pc      = (pc == `LPSE_PC_WRAP) ? `LPSE_PC_WRAP_TARGET : pc + 5'h01;
		need_pull   = cfg.autopull && (shift_cnt >= thresh_bits);
		src_word    = need_pull ? q_word : outgoing_shift_reg;
		src_cnt     = need_pull ? 6'h00 : shift_cnt;
		cnt_sum     = {1'b0, src_cnt} + {1'b0, out_bits};
		// Bits leaving the chosen end; count and direction
		if (cfg.shift_right) begin
			out_value = (out_bits == `LPSE_OSR_FULL_COUNT) ? src_word
				: (src_word & ((32'h0000_0001 << out_bits) - 32'h0000_0001));
		end else begin
			out_value = (out_bits == `LPSE_OSR_FULL_COUNT) ? src_word
				: (src_word >> (`LPSE_OSR_FULL_COUNT - out_bits));
		end
	end

	// Execution engine
	always_comb begin
		next_outgoing_shift_reg = outgoing_shift_reg;
		next_shift_cnt          = shift_cnt;
		next_pc                 = pc;
		next_delay_cnt          = delay_cnt;
		next_scratch_x          = scratch_x;
		next_stalled            = stalled;
		next_led_line           = led_line;
		pop                     = 1'b0;
		if (!cfg.enable) begin
			next_pc        = `LPSE_PC_WRAP_TARGET;
			next_delay_cnt = 4'h0;
			next_shift_cnt = `LPSE_OSR_FULL_COUNT;
			next_stalled   = 1'b0;
			next_led_line  = 1'b0;
		end else if (exec_tick) begin
			if (delay_cnt != 4'h0) begin
				next_delay_cnt = delay_cnt - 4'h1;
			end else begin
				next_led_line = instr.side;
				next_stalled  = 1'b0;
				case (instr.op)
					`LPSE_OP_OUT: begin
						if (need_pull && !q_full) begin
							next_stalled = 1'b1;
						end else begin
							pop            = need_pull;
							next_scratch_x = |out_value;
							next_outgoing_shift_reg = cfg.shift_right
								? (src_word >> out_bits) : (src_word << out_bits);
							next_shift_cnt = (cnt_sum > {1'b0, `LPSE_OSR_FULL_COUNT})
								? `LPSE_OSR_FULL_COUNT : cnt_sum[5:0];
							next_pc        = seq_pc;
							next_delay_cnt = instr.delay;
						end
					end
					`LPSE_OP_JMP: begin
						if ((instr.operand[7:5] == `LPSE_COND_ALWAYS)
							|| ((instr.operand[7:5] == `LPSE_COND_NOT_X) && !scratch_x)) begin
							next_pc = instr.operand[4:0];
						end else begin
							next_pc = seq_pc;
						end
						next_delay_cnt = instr.delay;
					end
					default: begin
						next_pc        = seq_pc;
						next_delay_cnt = instr.delay;
					end
				endcase
			end
		end
		// Background refill once threshold is reached
		if (cfg.enable && !pop && q_full && cfg.autopull && (next_shift_cnt >= thresh_bits)) begin
			pop                     = 1'b1;
			next_outgoing_shift_reg = q_word;
			next_shift_cnt          = 6'h00;
		end
	end

	// Register port and transmit queue
	always_comb begin
		next_cfg    = cfg;
		next_timing = timing;
		next_clkdiv = clkdiv;
		next_q_word = q_word;
		next_q_full = q_full && !pop;
		next_rdata  = 32'h0000_0000;
		if (wr) begin
			case (addr)
				`LPSE_ADDR_CTRL: begin
					next_cfg.enable      = wdata[`LPSE_CTRL_ENABLE];
					next_cfg.shift_right = wdata[`LPSE_CTRL_SHIFT_RIGHT];
					next_cfg.autopull    = wdata[`LPSE_CTRL_AUTOPULL];
					next_cfg.thresh      = wdata[`LPSE_CTRL_THRESH_HI:`LPSE_CTRL_THRESH_LO];
				end
				`LPSE_ADDR_CLKDIV: next_clkdiv = wdata[15:0];
				`LPSE_ADDR_TIMING: begin
					next_timing.lead  = wdata[`LPSE_TIM_LEAD_HI:`LPSE_TIM_LEAD_LO];
					next_timing.value = wdata[`LPSE_TIM_VALUE_HI:`LPSE_TIM_VALUE_LO];
					next_timing.gap   = wdata[`LPSE_TIM_GAP_HI:`LPSE_TIM_GAP_LO];
				end
				`LPSE_ADDR_TXDATA: begin
					// Push into a full queue is dropped unless the queue pops in the same cycle
					if (!q_full || pop) begin
						next_q_word = wdata;
						next_q_full = 1'b1;
					end
				end
				default: ;
			endcase
		end
		if (rd) begin
			case (addr)
				`LPSE_ADDR_CTRL: begin
					next_rdata[`LPSE_CTRL_ENABLE]      = cfg.enable;
					next_rdata[`LPSE_CTRL_SHIFT_RIGHT] = cfg.shift_right;
					next_rdata[`LPSE_CTRL_AUTOPULL]    = cfg.autopull;
					next_rdata[`LPSE_CTRL_THRESH_HI:`LPSE_CTRL_THRESH_LO] = cfg.thresh;
				end
				`LPSE_ADDR_CLKDIV: next_rdata[15:0] = clkdiv;
				`LPSE_ADDR_TIMING: begin
					next_rdata[`LPSE_TIM_LEAD_HI:`LPSE_TIM_LEAD_LO]   = timing.lead;
					next_rdata[`LPSE_TIM_VALUE_HI:`LPSE_TIM_VALUE_LO] = timing.value;
					next_rdata[`LPSE_TIM_GAP_HI:`LPSE_TIM_GAP_LO]     = timing.gap;
				end
				`LPSE_ADDR_STATUS: begin
					next_rdata[`LPSE_ST_QUEUE_FULL] = q_full;
					next_rdata[`LPSE_ST_STALLED]    = stalled;
					next_rdata[`LPSE_ST_LINE]       = led_line;
					next_rdata[`LPSE_ST_PC_HI:`LPSE_ST_PC_LO]   = pc[1:0];
					next_rdata[`LPSE_ST_CNT_HI:`LPSE_ST_CNT_LO] = shift_cnt;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cfg.enable         <= CTRL_RST[`LPSE_CTRL_ENABLE];
			cfg.shift_right    <= CTRL_RST[`LPSE_CTRL_SHIFT_RIGHT];
			cfg.autopull       <= CTRL_RST[`LPSE_CTRL_AUTOPULL];
			cfg.thresh         <= CTRL_RST[`LPSE_CTRL_THRESH_HI:`LPSE_CTRL_THRESH_LO];
			timing.lead        <= TIMING_RST[`LPSE_TIM_LEAD_HI:`LPSE_TIM_LEAD_LO];
			timing.value       <= TIMING_RST[`LPSE_TIM_VALUE_HI:`LPSE_TIM_VALUE_LO];
			timing.gap         <= TIMING_RST[`LPSE_TIM_GAP_HI:`LPSE_TIM_GAP_LO];
			clkdiv             <= CLKDIV_RESET;
			q_word             <= 32'h0000_0000;
			q_full             <= 1'b0;
			outgoing_shift_reg <= 32'h0000_0000;
			shift_cnt          <= `LPSE_OSR_FULL_COUNT;
			pc                 <= `LPSE_PC_WRAP_TARGET;
			delay_cnt          <= 4'h0;
			scratch_x          <= 1'b0;
			stalled            <= 1'b0;
			led_line           <= 1'b0;
			rdata              <= 32'h0000_0000;
		end else begin
			cfg                <= next_cfg;
			timing             <= next_timing;
			clkdiv             <= next_clkdiv;
			q_word             <= next_q_word;
			q_full             <= next_q_full;
			outgoing_shift_reg <= next_outgoing_shift_reg;
			shift_cnt          <= next_shift_cnt;
			pc                 <= next_pc;
			delay_cnt          <= next_delay_cnt;
			scratch_x          <= next_scratch_x;
			stalled            <= next_stalled;
			led_line           <= next_led_line;
			rdata              <= next_rdata;
		end
	end

endmodule : lpse_top

/* File: bench/lpse_top_properties.sv */
/*
 * Checker for the LED pulse stream encoder top: register read-back and
 * pulse widths on the LED line, from shadows of the host writes.
 * Assumes it is bound to lpse_top and sees only its ports.
 */
`timescale 1ns/1ps

`include "lpse_defs.svh"

module lpse_top_checker #(
	parameter logic [15:0] CLKDIV_RESET = `LPSE_CLKDIV_RESET
) (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic [7:0]  addr,
	input wire logic [31:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [31:0] rdata,
	input wire logic        led_line
);
	logic [31:0] ctrl_s;
	logic [31:0] tim_s;
	logic [31:0] div_s;
	logic        line_q;
	int          run;
	int          dv;
	int          t_lead;
	int          t_val;
	int          t_gap;

	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_s <= `LPSE_CTRL_RESET;
			tim_s  <= `LPSE_TIMING_RESET;
			div_s  <= {16'h0000, CLKDIV_RESET};
			line_q <= 1'b0;
			run    <= 0;
		end else begin
			if (wr && addr == `LPSE_ADDR_CTRL) ctrl_s <= wdata;
			if (wr && addr == `LPSE_ADDR_TIMING) tim_s <= wdata;
			if (wr && addr == `LPSE_ADDR_CLKDIV) div_s <= wdata;
			line_q <= led_line;
			run    <= (led_line == line_q) ? run + 1 : 1;
		end
	end

	// Level lengths in clocks, divider 0 acting as 1
	always_comb begin
		dv     = (div_s[15:0] == 16'h0000) ? 1 : int'(div_s[15:0]);
		t_lead = int'(tim_s[4:0]) * dv;
		t_val  = int'(tim_s[12:8]) * dv;
		t_gap  = int'(tim_s[20:16]) * dv;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
		else $error("read data not zero outside a read answer");
	a_unmapped_read_zero: assert property ($past(rd) && $past(addr) > 8'h10 |-> rdata == 32'h0000_0000)
		else $error("unmapped read returned nonzero");
	a_txdata_reads_zero: assert property ($past(rd) && $past(addr) == `LPSE_ADDR_TXDATA |-> rdata == 32'h0)
		else $error("transmit data read returned nonzero");
	a_ctrl_read_back: assert property ($past(rd) && $past(addr) == `LPSE_ADDR_CTRL |-> rdata[8:0] == ctrl_s[8:0])
		else $error("control read-back differs from last write");
	a_timing_read_back: assert property ($past(rd) && $past(addr) == `LPSE_ADDR_TIMING
		|-> {rdata[20:16], rdata[12:8], rdata[4:0]} == {tim_s[20:16], tim_s[12:8], tim_s[4:0]})
		else $error("timing read-back differs from last write");
	a_div_read_back: assert property ($past(rd) && $past(addr) == `LPSE_ADDR_CLKDIV |-> rdata[15:0] == div_s[15:0])
		else $error("divider read-back differs from last write");
	a_disabled_line_low: assert property (!ctrl_s[0] [*2] |-> !led_line)
		else $error("line high while disabled");
	a_pulse_high_width: assert property (line_q && !led_line |-> run == t_lead || run == t_lead + t_val)
		else $error("high pulse width is neither short nor long");
	a_low_gap_length: assert property (!line_q && led_line && ctrl_s[0] |-> run >= t_gap)
		else $error("low gap shorter than the gap count");
endmodule : lpse_top_checker

bind lpse_top lpse_top_checker #(.CLKDIV_RESET(CLKDIV_RESET)) chk_u (.clk(clk), .reset(reset), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .led_line(led_line));

/* File: bench/lpse_led_model.sv */
/*
 * Behavioural first LED of a chain: decodes pulse widths, keeps three
 * bytes, counts forwarded bits and latches on a long low.
 * Assumes the bench gives the high-width threshold in clocks.
 */
`timescale 1ns/1ps

module lpse_led_model #(
	parameter int LATCH = 60
) (
	input wire logic        clk,
	input wire logic        led_line,
	input wire logic [31:0] thresh,
	output logic [23:0]     color,
	output logic [31:0]     fwd,
	output logic [31:0]     latches
);
	logic        prev;
	logic [23:0] acc;
	int          run;
	int          nbits;
	int          fcnt;

	initial begin
		prev    = 1'b0;
		acc     = 24'h000000;
		run     = 0;
		nbits   = 0;
		fcnt    = 0;
		color   = 24'h000000;
		fwd     = 32'h0;
		latches = 32'h0;
	end

	always @(posedge clk) begin
		if (led_line != prev) begin
			if (prev) begin
				if (nbits < 24) acc <= {acc[22:0], run > int'(thresh)};
				else fcnt <= fcnt + 1;
				nbits <= nbits + 1;
			end
			run <= 1;
		end else begin
			run <= run + 1;
			if (!led_line && run == LATCH && nbits != 0) begin
				color   <= acc;
				fwd     <= 32'(fcnt);
				latches <= latches + 32'h1;
				nbits   <= 0;
				fcnt    <= 0;
			end
		end
		prev <= led_line;
	end
endmodule : lpse_led_model

/* File: bench/testbench.sv */
/*
 * Self-checking bench for the LED pulse stream encoder: register calls,
 * pushes of pixel words and colours seen by an LED model.
 * Assumes a 20 MHz clock and the checker bound to the top.
 */
`timescale 1ns/1ps

`include "lpse_defs.svh"

module testbench;
	localparam logic [15:0] DIV0 = 16'h0002;

	logic        clk;
	logic        reset;
	logic        wr;
	logic        rd;
	logic        led_line;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [31:0] got;
	logic [31:0] thresh;
	logic [31:0] fwd;
	logic [31:0] latches;
	logic [23:0] color;
	int          fail_count;
	int          check_count;
	int          k;

	lpse_top #(.CLKDIV_RESET(DIV0)) dut_u (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .led_line(led_line));
	lpse_led_model led_u (.clk(clk), .led_line(led_line), .thresh(thresh), .color(color), .fwd(fwd),
		.latches(latches));

	initial clk = 1'b0;
	always #25 clk = ~clk;

	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask : wr_reg

	task rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg

	task chk(input string n, input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task push(input logic [31:0] w);
		rd_reg(`LPSE_ADDR_STATUS, got);
		while (got[0] !== 1'b0) rd_reg(`LPSE_ADDR_STATUS, got);
		wr_reg(`LPSE_ADDR_TXDATA, w);
	endtask : push

	task wait_latch(input int n);
		for (k = 0; k < 8000 && latches < 32'(n); k++) @(posedge clk);
		chk("latches", latches, 32'(n));
	endtask : wait_latch

	task summarize;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize

	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		$display("[ERR] watchdog expected finish seen hang");
		summarize();
	end

	initial begin
		reset       = 1'b1;
		wr          = 1'b0;
		rd          = 1'b0;
		addr        = 8'h00;
		wdata       = 32'h0;
		thresh      = 32'd9;
		fail_count  = 0;
		check_count = 0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		rd_reg(`LPSE_ADDR_CTRL, got);
		chk("ctrl", got, `LPSE_CTRL_RESET);
		rd_reg(`LPSE_ADDR_TIMING, got);
		chk("timing", got, `LPSE_TIMING_RESET);
		rd_reg(`LPSE_ADDR_CLKDIV, got);
		chk("clkdiv", got, {16'h0000, DIV0});
		rd_reg(8'h24, got);
		chk("unmapped", got, 32'h0);
		rd_reg(`LPSE_ADDR_TXDATA, got);
		chk("txdata", got, 32'h0);
		$display("test reset_values done");
		wr_reg(`LPSE_ADDR_CTRL, `LPSE_CTRL_RESET | 32'h1);
		repeat (40) @(posedge clk);
		#1;
		chk("line_idle", {31'h0, led_line}, 32'h0);
		rd_reg(`LPSE_ADDR_STATUS, got);
		chk("stalled", {31'h0, got[1]}, 32'h1);
		push(32'ha5c3_0f00);
		wait_latch(1);
		chk("color_one", {8'h00, color}, 32'h00a5_c30f);
		chk("fwd_one", fwd, 32'h0);
		$display("test single_word done");
		push(32'h1234_56ff);
		push(32'hfedc_ba00);
		rd_reg(`LPSE_ADDR_STATUS, got);
		chk("full", {31'h0, got[0]}, 32'h1);
		wait_latch(2);
		chk("color_two", {8'h00, color}, 32'h0012_3456);
		chk("fwd_two", fwd, 32'd24);
		$display("test back_to_back done");
		// Boundary timings: lead 1, value 16, gap 3, divider 1
		wr_reg(`LPSE_ADDR_CTRL, `LPSE_CTRL_RESET);
		wr_reg(`LPSE_ADDR_TIMING, 32'h0003_1001);
		wr_reg(`LPSE_ADDR_CLKDIV, 32'h0000_0001);
		thresh <= 32'd9;
		wr_reg(`LPSE_ADDR_CTRL, 32'h0000_0007);
		push(32'h0000_00ff);
		wait_latch(3);
		chk("color_right", {8'h00, color}, 32'h00ff_0000);
		chk("fwd_right", fwd, 32'd8);
		$display("test shift_right done");
		summarize();
	end
endmodule : testbench
